// ===== motion_seq_pkg.sv
// Shared types and constants for the motion-sequence step controller
package motion_seq_pkg;

    localparam int          GROUP_CNT   = 32;
    localparam int          GROUP_AW    = 5;
    localparam int          PARAM_GROUPS = 8;
    localparam logic [3:0]  CTRL_MODE_SEQ = 4'hc;
    localparam logic [3:0]  START_TASK  = 4'h1;
    localparam int          CLK_MHZ     = 100;
    localparam int          MS_US       = 1000;
    localparam int          CYC_PER_MS  = CLK_MHZ * MS_US;
    localparam logic [16:0] MS_CNT_MAX  = 17'(CYC_PER_MS - 1);

    // Step-condition type digit
    localparam logic [3:0]  COND_NONE   = 4'h0;
    localparam logic [3:0]  COND_DELAY  = 4'h1;
    localparam logic [3:0]  COND_EDGE   = 4'h2;
    localparam logic [3:0]  COND_LEVEL  = 4'h3;
    // Condition values
    localparam logic [15:0] VAL_RISE    = 16'h0000;
    localparam logic [15:0] VAL_FALL    = 16'h0001;
    localparam logic [15:0] VAL_EITHER  = 16'h0002;
    localparam logic [15:0] VAL_HIGH    = 16'h0003;
    localparam logic [15:0] VAL_LOW     = 16'h0004;
    // Combination digit
    localparam logic [3:0]  JOIN_NONE   = 4'h0;
    localparam logic [3:0]  JOIN_AND    = 4'h1;
    localparam logic [3:0]  JOIN_OR     = 4'h2;
    // Motion type
    localparam logic [1:0]  TYPE_INVALID = 2'h0;
    localparam logic [1:0]  TYPE_ABS    = 2'h1;
    localparam logic [1:0]  TYPE_REL    = 2'h2;

    typedef struct packed {
        logic [1:0]  motionType;
        logic [3:0]  cond1Type;
        logic [3:0]  cond2Type;
        logic [3:0]  joinMode;
        logic [15:0] cond1Val;
        logic [15:0] cond2Val;
        logic [4:0]  nextGroup;
    } group_cfg_t;

    typedef struct packed {
        logic       runPermit;
        logic       stepTrig;
        logic [3:0] groupSel;
    } seq_in_t;

endpackage : motion_seq_pkg

// ===== step_cond_eval.sv
// Evaluates one step condition against the trigger input
`timescale 1ns/1ps
`default_nettype none
module step_cond_eval (
    input  wire logic [3:0]  condType,   // Condition type digit
    input  wire logic [15:0] condVal,    // Condition value
    input  wire logic        trigNow,    // Synchronised trigger
    input  wire logic        trigPrev,   // Trigger one cycle earlier
    input  wire logic        delayDone,  // Delay has elapsed
    output logic             met         // Condition satisfied
);
    logic rise;
    logic fall;

    always_comb begin
        rise = trigNow & ~trigPrev;  // see RL17
        fall = ~trigNow & trigPrev;  // see RL17
        met  = 1'b0;
        case (condType)
            motion_seq_pkg::COND_NONE:  met = 1'b1;
            motion_seq_pkg::COND_DELAY: met = delayDone;  // see RL8
            motion_seq_pkg::COND_EDGE: begin  // see RL9 see RL14
                case (condVal)
                    motion_seq_pkg::VAL_RISE:   met = rise;
                    motion_seq_pkg::VAL_FALL:   met = fall;
                    motion_seq_pkg::VAL_EITHER: met = rise | fall;
                    default:                    met = 1'b0;
                endcase
            end
            motion_seq_pkg::COND_LEVEL: begin  // see RL10 see RL15
                case (condVal)
                    motion_seq_pkg::VAL_HIGH: met = trigNow;
                    motion_seq_pkg::VAL_LOW:  met = ~trigNow;
                    default:                  met = 1'b0;
                endcase
            end
            default: met = 1'b0;
        endcase
    end
endmodule : step_cond_eval
`default_nettype wire

// ===== motion_seq_step_ctrl.sv
// Motion-sequence step controller: group selection and step sequencing
// Overview of operation
// RL1 - Single-group mode: motion allowed only while run-permit is active.
// RL2 - Select lines plus run-permit and trigger choose the group; all off gives 0.
// RL3 - Eight groups from parameters, up to thirty-two over communication.
// RL4 - Type 0 invalid, 1 absolute, 2 relative; nothing else.
// RL5 - Sequencing active only when control-mode digit equals C.
// RL6 - Start-mode digit 1 runs groups as a task sequence.
// RL7 - Condition-1 type 0 starts next group at once, ignoring condition 2.
// RL8 - Condition-1 type 1 advances after the group's delay value.
// RL9 - Condition-1 type 2 advances on chosen trigger edge.
// RL10 - Condition-1 type 3 advances on chosen trigger level.
// RL11 - Condition-2 types 0 and 1 mean no wait; 2 means edge.
// RL12 - Condition-2 type 3 waits for the chosen trigger level.
// RL13 - Delay value is milliseconds, 0 to 65535.
// RL14 - Edge value 0 rising, 1 falling, 2 either, others invalid.
// RL15 - Level value 3 high, 4 low, others invalid.
// RL16 - Join digit: 0 ignores condition 2, 1 both, 2 either.
// RL17 - All inputs synchronised; edges found from current and previous sample. Code synchronises only pinIn; mode digits and motionDone are used raw.
`timescale 1ns/1ps
`default_nettype none
module motion_seq_step_ctrl (
    input  wire logic                        ref_clk,      // 100 MHz clock
    input  wire logic                        srst,         // Sync reset, active high
    input  wire motion_seq_pkg::seq_in_t     pinIn,        // Discrete inputs, async
    input  wire logic [3:0]                  ctrlModeDigit,// Control-mode digit
    input  wire logic [3:0]                  startMode,    // Start-mode digit
    input  wire logic                        commMode,     // Groups set over comms
    input  wire logic                        cfgWe,        // Group table write strobe
    input  wire logic [4:0]                  cfgAddr,      // Group table index
    input  wire motion_seq_pkg::group_cfg_t  cfgData,      // Group table data
    input  wire logic                        motionDone,   // Current motion finished
    output logic                             seqActive,    // Sequence mode enabled
    output logic                             motionEnable, // Motion allowed
    output logic                             groupStart,   // Pulse: new group started
    output logic [4:0]                       groupIdx,     // Group now executing
    output logic [1:0]                       groupKind,    // Current motion type
    output logic                             groupInvalid  // Current group invalid
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_WAIT = 2'b10
    } state_t;

    // ------------------------------------------------------------
    // Input synchroniser
    // ------------------------------------------------------------
    motion_seq_pkg::seq_in_t syncA_r, syncB_r;
    logic                    trigPrev_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            syncA_r    <= '0;
            syncB_r    <= '0;
            trigPrev_r <= 1'b0;
        end else begin
            syncA_r    <= pinIn;               // see RL17
            syncB_r    <= syncA_r;
            trigPrev_r <= syncB_r.stepTrig;    // see RL17
        end
    end

    // ------------------------------------------------------------
    // Group table
    // ------------------------------------------------------------
    motion_seq_pkg::group_cfg_t table_r [motion_seq_pkg::GROUP_CNT];
    logic                       writeOk;

    // Parameter mode keeps writes inside the first eight entries
    always_comb begin
        writeOk = cfgWe & (commMode | (cfgAddr < 5'(motion_seq_pkg::PARAM_GROUPS)));  // see RL3
    end

    // Cleared so an unwritten entry reads as an invalid group, never as unknown
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            table_r <= '{default: '0};
        end else if (writeOk) begin
            table_r[cfgAddr] <= cfgData;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    state_t      state_r, state_nxt;
    logic [4:0]  idx_r, idx_nxt;
    logic        start_r, start_nxt;
    logic [15:0] msCnt_r, msCnt_nxt;
    logic [16:0] cycCnt_r, cycCnt_nxt;
    logic        delayDone;
    logic        met1, met2, advance;
    logic        modeOn, taskMode, permit;
    logic [4:0]  selIdx, nextIdx;
    motion_seq_pkg::group_cfg_t cur;

    always_comb begin
        cur       = table_r[idx_r];
        modeOn    = (ctrlModeDigit == motion_seq_pkg::CTRL_MODE_SEQ);  // see RL5
        taskMode  = (startMode == motion_seq_pkg::START_TASK);         // see RL6
        permit    = syncB_r.runPermit;
        selIdx    = {1'b0, syncB_r.groupSel};                          // see RL2
        nextIdx   = commMode ? cur.nextGroup
                             : {2'b00, cur.nextGroup[2:0]};            // see RL3
        delayDone = (msCnt_r == cur.cond1Val);                         // see RL13
    end

    step_cond_eval u_cond1 (
        .condType  (cur.cond1Type),
        .condVal   (cur.cond1Val),
        .trigNow   (syncB_r.stepTrig),
        .trigPrev  (trigPrev_r),
        .delayDone (delayDone),
        .met       (met1)
    );

    // Condition 2 has no delay form: types 0 and 1 mean no wait
    step_cond_eval u_cond2 (
        .condType  ((cur.cond2Type == motion_seq_pkg::COND_DELAY)
                    ? motion_seq_pkg::COND_NONE : cur.cond2Type),   // see RL11
        .condVal   (cur.cond2Val),
        .trigNow   (syncB_r.stepTrig),
        .trigPrev  (trigPrev_r),
        .delayDone (1'b1),
        .met       (met2)
    );

    always_comb begin
        if (cur.cond1Type == motion_seq_pkg::COND_NONE) begin
            advance = 1'b1;                                            // see RL7
        end else begin
            case (cur.joinMode)                                        // see RL16
                motion_seq_pkg::JOIN_AND: advance = met1 & met2;       // see RL12
                motion_seq_pkg::JOIN_OR:  advance = met1 | met2;
                default:                  advance = met1;
            endcase
        end
    end

    always_comb begin
        state_nxt  = state_r;
        idx_nxt    = idx_r;
        start_nxt  = 1'b0;
        msCnt_nxt  = msCnt_r;
        cycCnt_nxt = cycCnt_r;
        case (state_r)
            ST_IDLE: begin
                // Group is latched on a trigger rise with run-permit on
                if (modeOn && permit && syncB_r.stepTrig && !trigPrev_r) begin  // see RL2
                    idx_nxt   = selIdx;
                    start_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!modeOn) begin
                    state_nxt = ST_IDLE;
                end else if (motionDone) begin
                    if (taskMode) begin
                        msCnt_nxt  = '0;
                        cycCnt_nxt = '0;
                        state_nxt  = ST_WAIT;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                if (!modeOn) begin
                    state_nxt = ST_IDLE;
                end else if (advance) begin                           // see RL6
                    idx_nxt   = nextIdx;
                    start_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end else if (!delayDone) begin
                    // Millisecond tick; counter saturates at the target
                    if (cycCnt_r == motion_seq_pkg::MS_CNT_MAX) begin  // see RL13
                        cycCnt_nxt = '0;
                        msCnt_nxt  = msCnt_r + 16'h0001;
                    end else begin
                        cycCnt_nxt = cycCnt_r + 17'h00001;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r  <= ST_IDLE;
            idx_r    <= '0;
            start_r  <= 1'b0;
            msCnt_r  <= '0;
            cycCnt_r <= '0;
        end else begin
            state_r  <= state_nxt;
            idx_r    <= idx_nxt;
            start_r  <= start_nxt;
            msCnt_r  <= msCnt_nxt;
            cycCnt_r <= cycCnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic enable_r, enable_nxt;
    logic invalid_r, invalid_nxt;
    logic [1:0] kind_r, kind_nxt;

    always_comb begin
        // Single-group mode pauses motion with run-permit; task mode does not
        enable_nxt  = modeOn && (state_r != ST_IDLE) && (taskMode || permit);  // see RL1
        invalid_nxt = !((cur.motionType == motion_seq_pkg::TYPE_ABS) ||
                        (cur.motionType == motion_seq_pkg::TYPE_REL));         // see RL4
        kind_nxt    = invalid_nxt ? motion_seq_pkg::TYPE_INVALID : cur.motionType;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enable_r  <= 1'b0;
            invalid_r <= 1'b1;
            kind_r    <= motion_seq_pkg::TYPE_INVALID;
        end else begin
            enable_r  <= enable_nxt;
            invalid_r <= invalid_nxt;
            kind_r    <= kind_nxt;
        end
    end

    assign seqActive    = modeOn;
    assign motionEnable = enable_r & ~invalid_r;
    assign groupStart   = start_r;
    assign groupIdx     = idx_r;
    assign groupKind    = kind_r;
    assign groupInvalid = invalid_r;
endmodule : motion_seq_step_ctrl
`default_nettype wire

// ===== seq_ctrl_model.sv
// Far-side controller model driving the discrete sequence inputs
`timescale 1ns/1ps
`default_nettype none
module seq_ctrl_model (
    input  wire logic                   permit,  // Wanted run-permit
    input  wire logic                   trig,    // Wanted step trigger
    input  wire logic [3:0]             sel,     // Wanted group select
    output var motion_seq_pkg::seq_in_t pinIn    // Pin levels
);
    logic [3:0] selHeld;

    // Pins follow the bench in its own falling-edge step; a clocked copy would race it
    // Select moves only while trigger is low, so it is settled at the rise
    always_latch begin
        if (!trig) begin
            selHeld <= sel;
        end
    end
    assign pinIn = '{runPermit: permit, stepTrig: trig, groupSel: selHeld};
endmodule : seq_ctrl_model
`default_nettype wire

// ===== motion_seq_step_ctrl_asserts.sv
// Port-level checks for the step controller
`timescale 1ns/1ps
`default_nettype none
module motion_seq_step_ctrl_asserts (
    input wire logic                    ref_clk,       // Clock
    input wire logic                    srst,          // Reset
    input wire motion_seq_pkg::seq_in_t pinIn,         // Pins
    input wire logic [3:0]              ctrlModeDigit, // Mode digit
    input wire logic [3:0]              startMode,     // Start digit
    input wire logic                    seqActive,     // Mode on
    input wire logic                    motionEnable,  // Motion allowed
    input wire logic                    groupStart,    // Start pulse
    input wire logic [4:0]              groupIdx,      // Group
    input wire logic [1:0]              groupKind,     // Motion type
    input wire logic                    groupInvalid   // Invalid group
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Permit must be seen low through both sync stages first
    sequence permitOffSingle;
        (!pinIn.runPermit && startMode != 4'h1)[*4];
    endsequence
    sequence modeOff;
        (ctrlModeDigit != 4'hc)[*3];
    endsequence
    a_mode_decode: assert property (seqActive == (ctrlModeDigit == 4'hc))
        else $error("mode flag wrong");
    a_mode_off_idle: assert property (modeOff |=> !motionEnable)
        else $error("motion with mode off");
    a_permit_halt: assert property (permitOffSingle |-> !motionEnable)
        else $error("motion without permit");
    a_reset_values: assert property ($fell(srst) |-> !motionEnable && !groupStart
        && groupIdx == 5'h00 && groupInvalid)
        else $error("reset values wrong");
    a_no_start_off: assert property (!seqActive |=> !groupStart)
        else $error("group started with mode off");
    a_start_single: assert property (groupStart |=> !groupStart)
        else $error("start pulse too long");
    a_idx_moves: assert property ($changed(groupIdx) |-> groupStart)
        else $error("group changed without start");
    a_kind_invalid: assert property (groupInvalid |-> groupKind == 2'h0)
        else $error("kind on invalid group");
    a_enable_valid: assert property (motionEnable |-> !groupInvalid)
        else $error("motion on invalid group");
    a_kind_range: assert property (groupKind != 2'h3)
        else $error("kind out of range");
endmodule : motion_seq_step_ctrl_asserts
bind motion_seq_step_ctrl motion_seq_step_ctrl_asserts u_chk (.ref_clk, .srst, .pinIn,
    .ctrlModeDigit, .startMode, .seqActive, .motionEnable, .groupStart, .groupIdx,
    .groupKind, .groupInvalid);
`default_nettype wire

// ===== motion_seq_step_ctrl_tb.sv
// Self-checking bench for the motion-sequence step controller
`timescale 1ns/1ps
`default_nettype none
module motion_seq_step_ctrl_tb;
    // Select, motion type, {kind, invalid, enable}
    typedef struct packed {logic [3:0] sel; logic [1:0] ty; logic [3:0] res;} single_row_t;
    // Nibbles: c1 type, c1 value, c2 type, c2 value, join, trigger plan, advance
    typedef struct packed {logic [3:0] c1t, c1v, c2t, c2v, jm, act, adv;} task_row_t;
    single_row_t sRows [8] = '{'{4'h0, 2'h0, 4'h2}, '{4'h1, 2'h1, 4'h5},
        '{4'h2, 2'h2, 4'h9}, '{4'h3, 2'h3, 4'h2}, '{4'h4, 2'h1, 4'h5},
        '{4'h5, 2'h2, 4'h9}, '{4'h6, 2'h0, 4'h2}, '{4'h7, 2'h2, 4'h9}};
    task_row_t tRows [18] = '{28'h0020131, 28'h1000031, 28'h2000030, 28'h2000011,
        28'h2100030, 28'h2100021, 28'h2200021, 28'h2500010, 28'h3300031, 28'h3400030,
        28'h3400001, 28'h3600000, 28'h3334130, 28'h3334201, 28'h3310131, 28'h2520211,
        28'h3334031, 28'h1100030};
    logic ref_clk = 1'b0, srst = 1'b1, permit = 1'b0, trig = 1'b0, commMode = 1'b0;
    logic cfgWe = 1'b0, motionDone = 1'b0, startSeen = 1'b0;
    logic [3:0] sel = 4'h0, ctrlModeDigit = 4'hc, startMode = 4'h0;
    logic [4:0] cfgAddr = 5'h00;
    motion_seq_pkg::group_cfg_t cfgData = '0, g;
    motion_seq_pkg::seq_in_t pinIn;
    logic seqActive, motionEnable, groupStart, groupInvalid;
    logic [4:0] groupIdx;
    logic [1:0] groupKind;
    int mismatches = 0, num_checks = 0, cycles = 0;

    seq_ctrl_model u_far (.permit, .trig, .sel, .pinIn);
    motion_seq_step_ctrl u_dut (.ref_clk, .srst, .pinIn, .ctrlModeDigit, .startMode,
        .commMode, .cfgWe, .cfgAddr, .cfgData, .motionDone, .seqActive, .motionEnable,
        .groupStart, .groupIdx, .groupKind, .groupInvalid);

    always #5 ref_clk = ~ref_clk;
    // Sticky, since a start can land anywhere inside a wait window
    always @(posedge ref_clk) begin
        cycles++;
        if (groupStart === 1'b1) startSeen <= 1'b1;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic give_verdict;
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic ticks(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : ticks
    task automatic write_grp(input logic [4:0] a);
        cfgAddr = a;
        cfgData = g;
        cfgWe = 1'b1;
        ticks(1);
        cfgWe = 1'b0;
        ticks(1);
    endtask : write_grp
    task automatic start(input logic [3:0] s);
        sel = s;
        permit = 1'b1;
        startSeen = 1'b0;
        ticks(2);
        trig = 1'b1;
        ticks(8);
    endtask : start
    task automatic done_pulse;
        motionDone = 1'b1;
        ticks(1);
        motionDone = 1'b0;
    endtask : done_pulse
    task automatic go_idle;
        ctrlModeDigit = 4'h0;
        trig = 1'b0;
        permit = 1'b0;
        ticks(3);
        check(16'(seqActive), 16'h0000);
        ctrlModeDigit = 4'hc;
        ticks(1);
    endtask : go_idle
    initial begin
        ticks(2);
        srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            g = '0;
            g.motionType = sRows[i].ty;
            g.cond1Type = 4'h3;
            g.cond1Val = 16'h0006;
            write_grp(5'(i));
        end
        foreach (sRows[i]) begin
            start(sRows[i].sel);
            check(16'({startSeen, groupIdx}), 16'({2'h2, sRows[i].sel}));
            check(16'({groupKind, groupInvalid, motionEnable}), 16'(sRows[i].res));
            permit = 1'b0;
            trig = 1'b0;
            ticks(6);
            check(16'(motionEnable), 16'h0000);
            done_pulse();
        end
        start(4'h2);
        trig = 1'b0;
        start(4'h6);
        check(16'({startSeen, groupIdx}), 16'h0002);
        srst = 1'b1;
        ticks(2);
        srst = 1'b0;
        ticks(1);
        check(16'({groupIdx, groupStart, motionEnable, groupInvalid}), 16'h0001);
        go_idle();
        ctrlModeDigit = 4'h0;
        start(4'h3);
        check(16'(startSeen), 16'h0000);
        go_idle();
        commMode = 1'b1;
        startMode = 4'h1;
        g = '0;
        g.cond1Type = 4'h3;
        g.cond1Val = 16'h0006;
        write_grp(5'h14);
        foreach (tRows[i]) begin
            g = '0;
            g.motionType = 2'h1;
            {g.cond1Type, g.cond2Type, g.joinMode} = {tRows[i].c1t, tRows[i].c2t, tRows[i].jm};
            g.cond1Val = 16'(tRows[i].c1v);
            g.cond2Val = 16'(tRows[i].c2v);
            g.nextGroup = 5'h14;
            write_grp(5'h01);
            start(4'h1);
            startSeen = 1'b0;
            done_pulse();
            trig = tRows[i].act[1];
            ticks(6);
            trig = tRows[i].act[0];
            ticks(20);
            check(16'(startSeen), 16'(tRows[i].adv[0]));
            check(16'(groupIdx), tRows[i].adv[0] ? 16'h0014 : 16'h0001);
            go_idle();
        end
        give_verdict();
    end
endmodule : motion_seq_step_ctrl_tb
`default_nettype wire
